// ### src/bsp_port.v
`timescale 1ns/1ps
`include "bsp_regs.vh"

// write-posting fifo; width and depth shape the storage
module bsp_fifo #(
	parameter WIDTH = `BSP_ENT_W,
	parameter DEPTH = `BSP_FIFO_DEPTH,
	parameter AW = `BSP_FIFO_AW,
	parameter CW = `BSP_FIFO_CW
) (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_b_i,
	// filling side
	input wire in_valid_i,
	input wire [WIDTH-1:0] in_data_i,
	output wire in_ready_o,
	// draining side
	output wire out_valid_o,
	output wire [WIDTH-1:0] out_data_o,
	input wire out_ready_i
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [CW-1:0] count_ff;
	wire push;
	wire pop;

	// full and empty come straight from the occupancy count; the count is one
	// bit wider than the pointers, so sixteen held entries read as full
	// rather than wrapping round to empty
	assign in_ready_o = (count_ff != DEPTH[CW-1:0]);
	assign out_valid_o = (count_ff != {CW{1'b0}});
	assign out_data_o = store[rd_ptr_ff];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// pointers wrap by themselves at the power-of-two depth; the count
	// tracks occupancy
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {CW{1'b0}};
		end else begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			if (push & ~pop)
				count_ff <= count_ff + 1'b1;
			else if (pop & ~push)
				count_ff <= count_ff - 1'b1;
		end
	end

	// storage needs no reset; only written entries are ever read
	// leaving it unreset lets it map onto plain ram
	always @(posedge ref_clk_i) begin
		if (push)
			store[wr_ptr_ff] <= in_data_i;
	end
endmodule

module bsp_port (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_b_i,
	// memory clocks from the controller
	input wire k_i,
	input wire k_n_i,
	// command
	input wire load_strobe_n_i,
	input wire rw_i,
	input wire [`BSP_AW-1:0] addr_i,
	// write data
	input wire [`BSP_DW-1:0] d_i,
	input wire [`BSP_LANES-1:0] byte_lane_select_n_i,
	// read data
	output reg [`BSP_DW-1:0] q_o,
	output reg q_oe_o,
	// status
	output reg wr_overflow_o
);
	reg [`BSP_DW-1:0] array_mem [0:`BSP_DEPTH-1];
	reg k_d_ff;
	reg kn_d_ff;
	// write path state
	reg wr_p1_ff;
	reg [`BSP_AW-1:0] wr_a1_ff;
	reg wr_second_ff;
	reg [`BSP_AW-1:0] wr_a2_ff;
	// read path state: three command stages, then the second-word address
	reg rd_p1_ff;
	reg rd_p2_ff;
	reg rd_p3_ff;
	reg [`BSP_AW-1:0] rd_a1_ff;
	reg [`BSP_AW-1:0] rd_a2_ff;
	reg [`BSP_AW-1:0] rd_a3_ff;
	reg rd_second_ff;
	reg [`BSP_AW-1:0] rd_a4_ff;
	// capture slot in front of the fifo
	reg cap_vld_ff;
	reg [`BSP_ENT_W-1:0] cap_ent_ff;
	reg [`BSP_ENT_W-1:0] nxt_cap_ent;
	reg nxt_cap_take;
	wire k_rise;
	wire kn_rise;
	wire is_read;
	wire is_write;
	wire launch0;
	wire launch1;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [`BSP_ENT_W-1:0] fifo_out_data;
	wire drain_ready;
	wire drain;
	wire [`BSP_AW-1:0] drain_addr;
	wire [`BSP_LANES-1:0] drain_sel_n;
	wire [`BSP_DW-1:0] drain_data;
	// loop index for the lane-masked array write
	integer lane;

	// memory clocks are plain sampled inputs; a stopped clock gives no edge,
	// so every stage below holds its state except the capture slot and fifo, which keep draining
	// limitation: ref_clk must run at least four times the memory clock rate,
	// or an edge can slip between two samples
	assign k_rise = k_i & ~k_d_ff;
	assign kn_rise = k_n_i & ~kn_d_ff;

	// command decode on a K rise; load high is the idle command
	// the same k_rise term qualifies both, so a command is taken once per edge
	assign is_read = k_rise & ~load_strobe_n_i & rw_i;
	assign is_write = k_rise & ~load_strobe_n_i & ~rw_i;

	// launch edges of the two read words: word0 on the K-bar rise seen in
	// stage three, word1 on the K rise that follows it
	assign launch0 = kn_rise & rd_p3_ff;
	assign launch1 = k_rise & rd_second_ff;

	// the array port is taken by a read launch, so draining pauses then
	// a launch holds the port for one ref cycle only, so the fifo catches up
	// long before the word of any later read leaves
	assign drain_ready = ~(launch0 | launch1);
	assign drain = fifo_out_valid & drain_ready;
	assign drain_addr = fifo_out_data[`BSP_ENT_ADDR_LSB +: `BSP_AW];
	assign drain_sel_n = fifo_out_data[`BSP_ENT_SEL_LSB +: `BSP_LANES];
	assign drain_data = fifo_out_data[`BSP_ENT_DATA_LSB +: `BSP_DW];

	// edge detectors; parked-high clocks give no false edge after reset
	// a clock that is low at release only counts once it really rises, so
	// the first command is any K rise after reset
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			k_d_ff <= 1'b1;
			kn_d_ff <= 1'b1;
		end else begin
			k_d_ff <= k_i;
			kn_d_ff <= k_n_i;
		end
	end

	// write data phase: word0 at K of t+1, word1 at the following K-bar
	// selects travel with each word, so the two halves may mask differently;
	// outside these two edges d_i and the selects are never looked at
	always @* begin
		nxt_cap_take = 1'b0;
		nxt_cap_ent = cap_ent_ff;
		if (k_rise & wr_p1_ff) begin
			nxt_cap_take = 1'b1;
			nxt_cap_ent = {wr_a1_ff, byte_lane_select_n_i, d_i};
		end else if (kn_rise & wr_second_ff) begin
			nxt_cap_take = 1'b1;
			nxt_cap_ent = {wr_a2_ff, byte_lane_select_n_i, d_i};
		end
	end

	// write pipeline and capture slot in front of the fifo
	// wr_p1 marks that the last K rise took a write; wr_second opens the
	// K-bar half of its data phase
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			wr_p1_ff <= 1'b0;
			wr_a1_ff <= `BSP_ZERO_ADDR;
			wr_second_ff <= 1'b0;
			wr_a2_ff <= `BSP_ZERO_ADDR;
			cap_vld_ff <= 1'b0;
			cap_ent_ff <= `BSP_ZERO_ENT;
			wr_overflow_o <= 1'b0;
		end else begin
			if (k_rise) begin
				wr_p1_ff <= is_write;
				wr_a1_ff <= addr_i;
			end
			if (k_rise & wr_p1_ff) begin
				wr_second_ff <= 1'b1;
				wr_a2_ff <= wr_a1_ff + `BSP_ONE_ADDR;
			end else if (kn_rise & wr_second_ff) begin
				wr_second_ff <= 1'b0;
			end
			// slot stays full while the fifo refuses; a word arriving then overwrites it and the held word is lost
			if (nxt_cap_take) begin
				cap_vld_ff <= 1'b1;
				cap_ent_ff <= nxt_cap_ent;
				if (cap_vld_ff & ~fifo_in_ready)
					wr_overflow_o <= 1'b1;
			end else if (fifo_in_ready) begin
				cap_vld_ff <= 1'b0;
			end
		end
	end

	// sixteen entries absorb a run of bursts while read launches hold the
	// array port
	bsp_fifo #(
		.WIDTH(`BSP_ENT_W),
		.DEPTH(`BSP_FIFO_DEPTH),
		.AW(`BSP_FIFO_AW),
		.CW(`BSP_FIFO_CW)
	) u_post_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(cap_vld_ff),
		.in_data_i(cap_ent_ff),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_out_valid),
		.out_data_o(fifo_out_data),
		.out_ready_i(drain_ready)
	);

	// posted writes reach the array in order with lane masking
	// a lane whose select is high is not written and keeps its old contents;
	// all selects high leaves the word untouched
	always @(posedge ref_clk_i) begin
		if (drain) begin
			for (lane = 0; lane < `BSP_LANES; lane = lane + 1) begin
				if (!drain_sel_n[lane])
					array_mem[drain_addr][lane*`BSP_LANE_W +: `BSP_LANE_W] <=
						drain_data[lane*`BSP_LANE_W +: `BSP_LANE_W];
			end
		end
	end

	// read pipeline counted in K rises: a read taken at K(t) sits in stage
	// one until K(t+1), in stage two until K(t+2) and in stage three until
	// K(t+3), so the K-bar rise seen in stage three is K-bar(t+2) and the
	// burst leaves two and a half cycles after its command
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rd_p1_ff <= 1'b0;
			rd_p2_ff <= 1'b0;
			rd_p3_ff <= 1'b0;
			rd_a1_ff <= `BSP_ZERO_ADDR;
			rd_a2_ff <= `BSP_ZERO_ADDR;
			rd_a3_ff <= `BSP_ZERO_ADDR;
			rd_second_ff <= 1'b0;
			rd_a4_ff <= `BSP_ZERO_ADDR;
			q_o <= `BSP_ZERO_DATA;
			q_oe_o <= 1'b0;
		end else begin
			if (k_rise) begin
				rd_p1_ff <= is_read;
				rd_a1_ff <= addr_i;
				rd_p2_ff <= rd_p1_ff;
				rd_a2_ff <= rd_a1_ff;
				rd_p3_ff <= rd_p2_ff;
				rd_a3_ff <= rd_a2_ff;
			end
			// the array is read as the word leaves, so every write posted
			// before this edge has already drained; the newest data wins
			if (launch0) begin
				q_o <= array_mem[rd_a3_ff];
				q_oe_o <= 1'b1;
				rd_second_ff <= 1'b1;
				rd_a4_ff <= rd_a3_ff + `BSP_ONE_ADDR;
			end else if (kn_rise) begin
				// no new word0 on this K-bar rise: the burst is over and the
				// pins are released
				q_oe_o <= 1'b0;
			end
			// word1 waits for the next K rise, however long the clocks stop
			// in between
			if (launch1) begin
				q_o <= array_mem[rd_a4_ff];
				rd_second_ff <= 1'b0;
			end
		end
	end
endmodule

// ### src/bsp_regs.vh
`ifndef BSP_REGS_VH
`define BSP_REGS_VH

// array organisation: four lanes of nine bits
`define BSP_DW 36
`define BSP_LANES 4
`define BSP_LANE_W 9
// address width of the modelled array (kept small for simulation)
`define BSP_AW 8
`define BSP_DEPTH 256
// write-posting fifo
`define BSP_FIFO_DEPTH 16
`define BSP_FIFO_AW 4
`define BSP_FIFO_CW 5
// fifo entry layout: {address, lane selects, data}
`define BSP_ENT_W 48
`define BSP_ENT_DATA_LSB 0
`define BSP_ENT_SEL_LSB 36
`define BSP_ENT_ADDR_LSB 40
// reset and constant values
`define BSP_ZERO_DATA 36'h0_0000_0000
`define BSP_ZERO_ADDR 8'h00
`define BSP_ONE_ADDR 8'h01
`define BSP_ALL_OFF 4'hf
`define BSP_ZERO_ENT 48'h0000_0000_0000

`endif

// ### tb/bsp_ctl_model.sv
`timescale 1ns/1ps
// controller clocks; parked high while stopped for a quick restart
module bsp_ctl_model (
	// clock and run
	input wire ref_clk_i,
	input wire run_i,
	// memory clocks
	output reg k_o = 1'b1,
	output reg k_n_o = 1'b1
);
	reg [2:0] ph_ff = 3'h0;
	// k period of eight ref cycles keeps the 4x margin the port needs
	always @(posedge ref_clk_i) begin
		ph_ff <= run_i ? ph_ff + 3'h1 : 3'h0;
		k_o <= !run_i || ph_ff[2];
		k_n_o <= !run_i || !ph_ff[2];
	end
endmodule

// ### tb/bsp_port_chk.sv
`timescale 1ns/1ps
`include "bsp_regs.vh"
// figures assume a k period of eight ref cycles
module bsp_port_chk (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_b_i,
	// inputs
	input wire k_i,
	input wire k_n_i,
	input wire load_strobe_n_i,
	input wire rw_i,
	// outputs
	input wire [`BSP_DW-1:0] q_o,
	input wire q_oe_o,
	input wire wr_overflow_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_reset_quiet: assert property ($rose(rst_b_i) |->
		!q_oe_o && q_o == 36'h0 && !wr_overflow_o) else $error("not quiet");
	a_oe_kbar: assert property ($rose(q_oe_o) |-> k_n_i) else $error("oe off kbar");
	a_oe_cmd: assert property ($rose(q_oe_o) |->
		$past(!load_strobe_n_i && rw_i, 22)) else $error("oe without read");
	a_oe_span: assert property ($rose(q_oe_o) |-> q_oe_o[*8]) else $error("short");
	a_oe_drop: assert property ($fell(q_oe_o) |-> k_n_i) else $error("drop off kbar");
	a_stop_hold: assert property ((k_i && k_n_i)[*3] |=>
		$stable(q_o) && $stable(q_oe_o)) else $error("moved while stopped");
	a_q_edge: assert property ($changed(q_o) |->
		k_i != $past(k_i, 3) || k_n_i != $past(k_n_i, 3)) else $error("q off edge");
	a_ovf_sticky: assert property (wr_overflow_o |=> wr_overflow_o) else $error("ovf");
endmodule
bind bsp_port bsp_port_chk u_bsp_port_chk (.ref_clk_i, .rst_b_i, .k_i, .k_n_i,
	.load_strobe_n_i, .rw_i, .q_o, .q_oe_o, .wr_overflow_o);

// ### tb/bsp_port_tb.sv
`timescale 1ns/1ps
module bsp_port_tb;
	reg clk, rst_b, run, load_n, rw;
	reg [7:0] addr;
	reg [35:0] d;
	reg [3:0] sel;
	wire k, k_n, q_oe, ovf;
	wire [35:0] q;
	integer n_errors = 0, checked = 0, cyc = 0;
	bsp_ctl_model u_bsp_ctl_model (.ref_clk_i(clk), .run_i(run), .k_o(k), .k_n_o(k_n));
	bsp_port u_bsp_port (.ref_clk_i(clk), .rst_b_i(rst_b), .k_i(k), .k_n_i(k_n),
		.load_strobe_n_i(load_n), .rw_i(rw), .addr_i(addr), .d_i(d),
		.byte_lane_select_n_i(sel), .q_o(q), .q_oe_o(q_oe), .wr_overflow_o(ovf));
	task print_verdict;
		begin
			$display("errors %0d checks %0d", n_errors, checked);
			if (n_errors == 0 && checked > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [35:0] got, input [35:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("Error %0t: %h vs %h", $time, got, exp);
			end
		end
	endtask
	// two ref cycles past a k edge, clear of the edge detector
	task at_k(input pos);
		begin
			if (pos) @(posedge k);
			else @(negedge k);
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
	task cmd(input r, input [7:0] a);
		begin
			at_k(1'b0);
			load_n = 1'b0;
			rw = r;
			addr = a;
			d = ~d; // junk with all lanes on outside the data phase
			sel = 4'h0;
		end
	endtask
	task wr(input [7:0] a, input [35:0] d0, input [3:0] s0, input [35:0] d1, input [3:0] s1);
		begin
			cmd(1'b0, a);
			at_k(1'b0);
			load_n = 1'b1;
			d = d0;
			sel = s0;
			at_k(1'b1);
			d = d1;
			sel = s1;
		end
	endtask
	task rd(input [7:0] a, input [35:0] e0, input [35:0] e1);
		begin
			cmd(1'b1, a);
			at_k(1'b0);
			load_n = 1'b1;
			at_k(1'b0);
			at_k(1'b0);
			chk(q, e0);
			chk({35'h0, q_oe}, 36'h1);
			at_k(1'b1);
			chk(q, e1);
			at_k(1'b0);
			chk({35'h0, q_oe}, 36'h0);
		end
	endtask
	// burst wraps at the top address; read right behind the write
	task t_wrap;
		begin
			wr(8'hff, 36'h1_2345_6789, 4'h0, 36'h9_8765_4321, 4'h0);
			rd(8'hff, 36'h1_2345_6789, 36'h9_8765_4321);
		end
	endtask
	// one lane per write on word0, word1 fully masked
	task t_lanes;
		integer i;
		reg [8:0] p;
		reg [35:0] e;
		begin
			e = 36'h0;
			wr(8'h20, e, 4'h0, e, 4'h0);
			for (i = 0; i < 4; i = i + 1) begin
				p = 9'h001 << i;
				e[9*i +: 9] = p;
				wr(8'h20, {p, p, p, p}, ~(4'h1 << i), ~e, 4'hf);
			end
			rd(8'h20, e, 36'h0);
		end
	endtask
	// parked clocks keep the last outputs; a read after restart still works
	task t_stop;
		begin
			rd(8'hff, 36'h1_2345_6789, 36'h9_8765_4321);
			run = 1'b0;
			repeat (20) @(posedge clk);
			#1;
			chk(q, 36'h9_8765_4321);
			chk({35'h0, q_oe}, 36'h0);
			run = 1'b1;
			rd(8'hff, 36'h1_2345_6789, 36'h9_8765_4321);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_b, run, load_n, rw, addr, d, sel} = {3'h1, 45'h0, 4'hf};
		repeat (8) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk({35'h0, q_oe}, 36'h0);
		run = 1'b1;
		t_wrap;
		t_lanes;
		t_stop;
		chk({35'h0, ovf}, 36'h0);
		print_verdict;
	end
	// hang guard, far beyond the few hundred cycles needed
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_errors = n_errors + 1;
			print_verdict;
		end
	end
endmodule
